//--- include/thermo_cmd_defines.svh
// Constants of the thermometer command interpreter: command codes,
// status layout, reset values and timing counts.
// Assumes the core clock of 125 MHz given by CLK_PERIOD_NS.
`ifndef THERMO_CMD_DEFINES_SVH
`define THERMO_CMD_DEFINES_SVH
`define CMD_HALT 8'h22
`define CMD_BEGIN 8'hee
`define CMD_FETCH 8'haa
`define CMD_STORAGE 8'h17
`define CMD_SETUP 8'hac
// Fixed device code of the selection byte; the value is arbitrary.
`define DEV_CODE 4'h9
`define CFG_FIXED 6'h25
`define SINGLE_RST 1'b0
`define TEMP_RST 13'h0000
`define BYTE_BITS 4'h8
`define CLK_PERIOD_NS 8
`define PROG_TIME_MS 10
`define CONV_TIME_MS 1000
`define PROG_CYCLES ((`PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define CONV_CYCLES ((`CONV_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`endif

//--- include/thermo_cmd_pkg.sv
// Types shared by the thermometer command interpreter.
// Assumes nothing of its surroundings.
package thermo_cmd_pkg;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_type;
    typedef enum logic [8:0] {
        L_IDLE = 9'h001,
        L_ADDR = 9'h002,
        L_AACK = 9'h004,
        L_CMD = 9'h008,
        L_CACK = 9'h010,
        L_WDATA = 9'h020,
        L_WACK = 9'h040,
        L_RDATA = 9'h080,
        L_RACK = 9'h100
    } link_state_type;
endpackage

//--- design/thermometer_command_interpreter.sv
// Command interpreter of a 2-wire serial thermometer with 256 bytes of storage.
// Assumes bus pins sampled on i_link_clock at least 8 times per bus bit and a
// sensor value valid in the i_clock domain whenever a conversion ends.
//
// How it works
// [RQ1] Halt code stops further conversions and takes no data bytes.
// [RQ2] A running conversion still finishes after halt, then the converter idles.
// [RQ3] Fetch code returns two bytes of the latest finished result.
// [RQ4] In continuous mode halt ends repeats until a new begin code.
// [RQ5] In single mode each begin code gives exactly one conversion.
// [RQ6] Storage code gives access to 256 bytes; write data follows.
// [RQ7] Setup code gives access to the configuration byte; write data follows.
// [RQ8] Master should wait the programming time after a nonvolatile write.
// [RQ9] During programming no bus access is acknowledged.
// [RQ10] Selection byte with write bit, then command byte, both acknowledged.
// [RQ11] Setup code then zero byte selects continuous mode, ended by STOP.
// [RQ12] Begin code is acknowledged and followed directly by STOP.
// [RQ13] Fetch, repeated START, selection byte with read bit, acknowledged.
// [RQ14] Result goes out high byte first, then low byte after master acknowledge.
// [RQ15] Selection byte holds device code, select pins, then read/write bit.
// [RQ16] Single select bit picks mode; done flag is zero while converting.
// [RQ17] Result is 13 bits left aligned; three low bits of byte two are zero.
// [RQ18] Master ends the read with not-acknowledge and STOP.
`timescale 1ns/1ps
`include "thermo_cmd_defines.svh"
module thermometer_command_interpreter
    import thermo_cmd_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
    parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_link_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [2:0] i_select_pins,
    input wire logic [12:0] i_sensor_value,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_converting,
    output logic o_prog_busy
);
    // Core domain state.
    logic [3:0] tg_s1_r, tg_s2_r, tg_s3_r, ev;
    conv_state_type st_r;
    logic run_r, done_r, single_r, busy_r, dtg_r, conv_end;
    logic [31:0] ccnt_r, pcnt_r;
    logic [12:0] temp_r;
    // Link domain state.
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic [2:0] sel_s1, sel_s2;
    logic bsy_s1, bsy_s2, dn_s1, dn_s2, one_s1, one_s2, dtg_s1, dtg_s2, dtg_s3;
    logic scl_rise, scl_fall, start_det, stop_det, byte_end, busy_l, known;
    link_state_type lst_r;
    logic [3:0] cnt_r, tg_r;
    logic [7:0] sh_r, cmd_r, ptr_r, tx_r, cfg_data_r, tx_byte;
    logic rw_r, first_r, rd_idx_r, oe_r, nvw_r, pend_r, mem_we;
    logic [12:0] ltemp_r;
    logic [7:0] mem [256];

    // Event toggles from the link, index 0 begin, 1 halt, 2 setup, 3 program.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tg_s1_r <= 4'h0;
            tg_s2_r <= 4'h0;
            tg_s3_r <= 4'h0;
        end else begin
            tg_s1_r <= tg_r;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end
    assign ev = tg_s2_r ^ tg_s3_r;
    assign conv_end = (st_r == CONV_RUN) && (ccnt_r == CONV_CYCLES - 1);

    // Setup data is held still by the link until the next toggle, so one bit is safe.
    // [RQ16] mode select bit
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            single_r <= `SINGLE_RST;
        end else if (ev[2]) begin
            single_r <= cfg_data_r[0];
        end
    end

    // A begin arriving with a halt or a conversion end wins over the clear.
    // [RQ1] [RQ4] [RQ5] run request
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_r <= 1'b0;
        end else if (ev[0]) begin
            run_r <= 1'b1;
        end else if (ev[1] || (conv_end && single_r)) begin
            run_r <= 1'b0;
        end
    end

    // Converter sequencing; the analog part is stood in for by a fixed time.
    // [RQ2] finish then idle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= CONV_IDLE;
            ccnt_r <= 32'h0;
            done_r <= 1'b1;
            temp_r <= `TEMP_RST;
            dtg_r <= 1'b0;
        end else begin
            case (st_r)
                CONV_IDLE: begin
                    if (run_r) begin
                        st_r <= CONV_RUN;
                        ccnt_r <= 32'h0;
                        done_r <= 1'b0;
                    end
                end
                CONV_RUN: begin
                    if (conv_end) begin
                        st_r <= CONV_IDLE;
                        done_r <= 1'b1;
                        temp_r <= i_sensor_value;
                        dtg_r <= ~dtg_r;
                    end else begin
                        ccnt_r <= ccnt_r + 32'h1;
                    end
                end
                default: begin
                    st_r <= CONV_IDLE;
                end
            endcase
        end
    end
    assign o_converting = st_r[1];

    // Nonvolatile programming timer started by a STOP after a write.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
            pcnt_r <= 32'h0;
        end else if (ev[3]) begin
            busy_r <= 1'b1;
            pcnt_r <= 32'h0;
        end else if (busy_r) begin
            busy_r <= (pcnt_r != PROG_CYCLES - 1);
            pcnt_r <= pcnt_r + 32'h1;
        end
    end
    assign o_prog_busy = busy_r;

    // Pin and status synchronisers; only the second and third stages feed logic.
    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
            {sel_s1, sel_s2} <= 6'h00;
            {bsy_s1, bsy_s2, dn_s1, dn_s2, one_s1, one_s2} <= 6'h00;
            {dtg_s1, dtg_s2, dtg_s3} <= 3'h0;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
            {sel_s1, sel_s2} <= {i_select_pins, sel_s1};
            {bsy_s1, bsy_s2} <= {busy_r, bsy_s1};
            {dn_s1, dn_s2} <= {done_r, dn_s1};
            {one_s1, one_s2} <= {single_r, one_s1};
            {dtg_s1, dtg_s2, dtg_s3} <= {dtg_r, dtg_s1, dtg_s2};
        end
    end
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_det = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
    assign byte_end = scl_fall && (cnt_r == `BYTE_BITS);
    assign busy_l = pend_r | bsy_s2;

    // Result copy; the core word is still for a whole conversion after its toggle.
    // [RQ3] latest result
    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ltemp_r <= `TEMP_RST;
        end else if (dtg_s2 ^ dtg_s3) begin
            ltemp_r <= temp_r;
        end
    end

    // Busy covers the gap before the core timer echoes back; the set wins.
    // [RQ9] busy window
    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_r <= 1'b0;
        end else if (stop_det && nvw_r) begin
            pend_r <= 1'b1;
        end else if (bsy_s2) begin
            pend_r <= 1'b0;
        end
    end

    function automatic logic code_known(input logic [7:0] c);
        code_known = (c == `CMD_HALT) || (c == `CMD_BEGIN) || (c == `CMD_FETCH) ||
                     (c == `CMD_STORAGE) || (c == `CMD_SETUP);
    endfunction
    assign known = code_known(sh_r);

    // Byte handed to the master on a read.
    // [RQ14] [RQ17] byte order
    always_comb begin
        case (cmd_r)
            `CMD_FETCH: tx_byte = rd_idx_r ? {ltemp_r[4:0], 3'h0} : ltemp_r[12:5];
            `CMD_SETUP: tx_byte = {dn_s2, `CFG_FIXED, one_s2};
            `CMD_STORAGE: tx_byte = mem[ptr_r];
            default: tx_byte = 8'h00;
        endcase
    end
    assign mem_we = (lst_r == L_WDATA) && byte_end && (cmd_r == `CMD_STORAGE) && !first_r;

    // Storage array; a page write advances only the low three pointer bits.
    // [RQ6] storage write
    always_ff @(posedge i_link_clock) begin
        if (mem_we) begin
            mem[ptr_r] <= sh_r;
        end
    end

    // Bus slave sequencing; START and STOP take priority over bit events.
    always_ff @(posedge i_link_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lst_r <= L_IDLE;
            {cnt_r, tg_r} <= 8'h00;
            {sh_r, cmd_r, ptr_r, tx_r, cfg_data_r} <= 40'h0;
            {rw_r, first_r, rd_idx_r, oe_r, nvw_r} <= 5'h00;
        end else if (start_det) begin
            lst_r <= L_ADDR;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (stop_det) begin
            lst_r <= L_IDLE;
            oe_r <= 1'b0;
            if (nvw_r) begin
                tg_r[3] <= ~tg_r[3];
                nvw_r <= 1'b0;
            end
        end else begin
            if (scl_rise && (lst_r == L_ADDR || lst_r == L_CMD || lst_r == L_WDATA)) begin
                sh_r <= {sh_r[6:0], sda_s2};
                cnt_r <= cnt_r + 4'h1;
            end
            case (lst_r)
                L_ADDR: begin
                    // [RQ9] [RQ10] [RQ15] address match
                    if (byte_end) begin
                        if (sh_r[7:1] == {`DEV_CODE, sel_s2} && !busy_l) begin
                            oe_r <= 1'b1;
                            rw_r <= sh_r[0];
                            lst_r <= L_AACK;
                        end else begin
                            lst_r <= L_IDLE;
                        end
                    end
                end
                L_AACK: begin
                    // [RQ13] read start
                    if (scl_fall) begin
                        cnt_r <= rw_r ? 4'h1 : 4'h0;
                        oe_r <= rw_r & ~tx_byte[7];
                        tx_r <= tx_byte;
                        lst_r <= rw_r ? L_RDATA : L_CMD;
                        if (rw_r && cmd_r == `CMD_STORAGE) begin
                            ptr_r <= ptr_r + 8'h1;
                        end
                        if (rw_r && cmd_r == `CMD_FETCH) begin
                            rd_idx_r <= 1'b1;
                        end
                    end
                end
                L_CMD: begin
                    // [RQ1] [RQ10] [RQ12] command decode
                    if (byte_end) begin
                        cmd_r <= sh_r;
                        oe_r <= known;
                        lst_r <= known ? L_CACK : L_IDLE;
                        first_r <= 1'b1;
                        rd_idx_r <= 1'b0;
                        if (sh_r == `CMD_BEGIN) begin
                            tg_r[0] <= ~tg_r[0];
                        end
                        if (sh_r == `CMD_HALT) begin
                            tg_r[1] <= ~tg_r[1];
                        end
                    end
                end
                L_CACK: begin
                    if (scl_fall) begin
                        oe_r <= 1'b0;
                        cnt_r <= 4'h0;
                        lst_r <= (cmd_r == `CMD_STORAGE || cmd_r == `CMD_SETUP) ?
                                 L_WDATA : L_IDLE;
                    end
                end
                L_WDATA: begin
                    // [RQ6] [RQ7] [RQ11] write data
                    if (byte_end) begin
                        oe_r <= 1'b1;
                        lst_r <= L_WACK;
                        if (cmd_r == `CMD_SETUP) begin
                            cfg_data_r <= sh_r;
                            tg_r[2] <= ~tg_r[2];
                            nvw_r <= 1'b1;
                        end else if (first_r) begin
                            ptr_r <= sh_r;
                            first_r <= 1'b0;
                        end else begin
                            ptr_r <= {ptr_r[7:3], ptr_r[2:0] + 3'h1};
                            nvw_r <= 1'b1;
                        end
                    end
                end
                L_WACK: begin
                    if (scl_fall) begin
                        oe_r <= 1'b0;
                        cnt_r <= 4'h0;
                        lst_r <= L_WDATA;
                    end
                end
                L_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == `BYTE_BITS) begin
                            oe_r <= 1'b0;
                            lst_r <= L_RACK;
                        end else begin
                            oe_r <= ~tx_r[6];
                            tx_r <= {tx_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                end
                L_RACK: begin
                    // An acknowledge reuses the load path of the address acknowledge stage.
                    if (scl_rise) begin
                        lst_r <= sda_s2 ? L_IDLE : L_AACK;
                    end
                end
                default: begin
                    oe_r <= 1'b0;
                end
            endcase
        end
    end
    assign o_sda_oe = oe_r;
    assign o_sda_out = 1'b0;

    property p_halt_clears;
        @(posedge i_clock) disable iff (!i_rst_n) ev[1] && !ev[0] |=> !run_r;
    endproperty
    a_halt_clears: assert property (p_halt_clears) else $error("halt left run set"); // [RQ1]
    property p_finish_idle;
        @(posedge i_clock) disable iff (!i_rst_n)
            conv_end && !run_r && !ev[0] |=> st_r == CONV_IDLE && done_r ##1 st_r == CONV_IDLE;
    endproperty
    a_finish_idle: assert property (p_finish_idle) else $error("no idle after halt"); // [RQ2]
    property p_cont_repeat;
        @(posedge i_clock) disable iff (!i_rst_n)
            conv_end && run_r && !single_r && !ev[1] |=> ##1 st_r == CONV_RUN;
    endproperty
    a_cont_repeat: assert property (p_cont_repeat) else $error("continuous stopped"); // [RQ4]
    property p_single_once;
        @(posedge i_clock) disable iff (!i_rst_n)
            conv_end && single_r && !ev[0] |=> (st_r == CONV_IDLE) [*2];
    endproperty
    a_single_once: assert property (p_single_once) else $error("single repeated"); // [RQ5]
    property p_done_flag;
        @(posedge i_clock) disable iff (!i_rst_n)
            st_r == CONV_RUN && !conv_end |=> !done_r;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done high in conversion"); // [RQ16]
    property p_busy_nack;
        @(posedge i_link_clock) disable iff (!i_rst_n)
            lst_r == L_ADDR && byte_end && !start_det && !stop_det && busy_l
            |=> lst_r == L_IDLE && !oe_r;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("ack while busy"); // [RQ9]
    property p_addr_ack;
        @(posedge i_link_clock) disable iff (!i_rst_n)
            lst_r == L_ADDR && byte_end && !start_det && !stop_det && !busy_l &&
            sh_r[7:1] == {`DEV_CODE, sel_s2} |=> lst_r == L_AACK && oe_r;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // [RQ15]
    property p_begin_toggle;
        @(posedge i_link_clock) disable iff (!i_rst_n)
            lst_r == L_CMD && byte_end && !start_det && !stop_det && sh_r == `CMD_BEGIN
            |=> tg_r[0] != $past(tg_r[0]) && lst_r == L_CACK;
    endproperty
    a_begin_toggle: assert property (p_begin_toggle) else $error("begin not passed"); // [RQ12]
    // The second result byte as loaded into the shifter, not the mux feeding it.
    property p_low_zero;
        @(posedge i_link_clock) disable iff (!i_rst_n)
            lst_r == L_AACK && scl_fall && rw_r && rd_idx_r && cmd_r == `CMD_FETCH &&
            !start_det && !stop_det |=> tx_r[2:0] == 3'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low result bits set"); // [RQ17]
    c_conv: cover property (@(posedge i_clock) disable iff (!i_rst_n) conv_end);
    c_prog: cover property (@(posedge i_clock) disable iff (!i_rst_n) ev[3]);
    c_read: cover property (@(posedge i_link_clock) disable iff (!i_rst_n)
        lst_r == L_RACK && rd_idx_r && scl_rise && sda_s2);
endmodule

//--- bench/bus_master_model.sv
// Behavioural master of the 2-wire bus that faces the thermometer.
// Assumes the bench resolves SDA with a pull-up and paces it by the core clock.
`timescale 1ns/1ps
module bus_master_model #(
    parameter int Q = 40
) (
    input wire logic i_clock,
    input wire logic i_sda,
    input wire logic i_slow,
    output logic o_scl,
    output logic o_sda
);
    // Both lines released, so the bus clock stands still between frames.
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // One quarter of a bit; every change lands on a falling core clock edge.
    task automatic wq();
        repeat (Q) @(negedge i_clock);
    endtask

    task automatic start_cond();
        wq();
        o_sda = 1'b1;
        wq();
        o_scl = 1'b1;
        wq();
        o_sda = 1'b0;
        wq();
        o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        wq();
        o_sda = 1'b0;
        wq();
        o_scl = 1'b1;
        wq();
        o_sda = 1'b1;
        wq();
    endtask

    // Data changes only in the low phase, a quarter bit before the rise, so the
    // slave's late release never looks like a start or stop. Slow mode
    // stretches the low phase as a sluggish master would.
    task automatic xfer_bit(input logic b, output logic r);
        wq();
        if (i_slow) begin
            repeat (3) wq();
        end
        o_sda = b;
        wq();
        o_scl = 1'b1;
        wq();
        r = i_sda;
        wq();
        o_scl = 1'b0;
    endtask

    // byte out, most significant bit first.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask

    // byte in, then ack or not-ack.
    task automatic read_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(~ack_it, r);
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench of the thermometer command interpreter.
// Assumes the bus master model and short conversion and programming counts.
`timescale 1ns/1ps
`include "thermo_cmd_defines.svh"
module tb_top;
    localparam int PROG = 2500;
    localparam int CONV = 100;
    localparam int LIMIT = 100000;
    logic i_clock, i_link_clock, i_rst_n, scl, sda_m, slow, sda_w;
    logic sda_out, sda_oe, converting, prog_busy, conv_q;
    logic [2:0] pins;
    logic [12:0] sensor;
    int fails, n_compared, rises, cycles;

    // Open-drain wire: pulled up unless a party pulls it low.
    assign sda_w = sda_m & ~(sda_oe & ~sda_out);

    thermometer_command_interpreter #(.PROG_CYCLES(PROG), .CONV_CYCLES(CONV)) dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clock(i_link_clock),
        .i_scl(scl), .i_sda(sda_w), .i_select_pins(pins), .i_sensor_value(sensor),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_converting(converting),
        .o_prog_busy(prog_busy));

    bus_master_model #(.Q(40)) m (.i_clock(i_clock), .i_sda(sda_w), .i_slow(slow),
        .o_scl(scl), .o_sda(sda_m));

    // Core clock.
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // Link clock, offset so its phase bears no relation to the core clock.
    initial begin
        i_link_clock = 1'b0;
        #37;
        forever #62.5 i_link_clock = ~i_link_clock;
    end

    // Counts conversion starts and cuts a hung run short.
    always @(posedge i_clock) begin
        conv_q <= converting;
        if (converting === 1'b1 && conv_q === 1'b0) begin
            rises <= rises + 1;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask

    function automatic logic [7:0] sel(input logic rw);
        return {`DEV_CODE, pins, rw};
    endfunction

    task automatic open_cmd(input logic [7:0] cmd, output logic a0, output logic a1);
        m.start_cond();
        m.write_byte(sel(1'b0), a0);
        m.write_byte(cmd, a1);
    endtask

    task automatic turn_read();
        logic a;
        m.start_cond();
        m.write_byte(sel(1'b1), a);
        chk(a, 1, "read select ack");
    endtask

    // Waits out a programming cycle, probing the bus while it runs.
    task automatic wait_prog();
        int n;
        logic a;
        n = 0;
        while (prog_busy !== 1'b1 && n < 200) begin
            @(negedge i_clock);
            n++;
        end
        chk(prog_busy, 1, "programming started");
        m.start_cond();
        m.write_byte(sel(1'b0), a);
        chk(a, 0, "access while programming");
        m.stop_cond();
        n = 0;
        while (prog_busy !== 1'b0 && n < PROG + 200) begin
            @(negedge i_clock);
            n++;
        end
        chk(prog_busy, 0, "programming ended");
    endtask

    task automatic t_select();
        logic a0, a1;
        m.start_cond();
        m.write_byte({`DEV_CODE, ~pins, 1'b0}, a0);
        chk(a0, 0, "foreign select pins");
        m.stop_cond();
        open_cmd(8'h55, a0, a1);
        chk(a0, 1, "select ack");
        chk(a1, 0, "unknown command");
        m.stop_cond();
        end_test("select");
    endtask

    task automatic t_continuous();
        int r0;
        logic a0, a1;
        r0 = rises;
        open_cmd(`CMD_BEGIN, a0, a1);
        chk(a1, 1, "begin ack");
        m.stop_cond();
        repeat (400) @(negedge i_clock);
        chk(rises - r0 > 2, 1, "repeated conversions");
        open_cmd(`CMD_HALT, a0, a1);
        chk(a1, 1, "halt ack");
        m.write_byte(8'h00, a0);
        chk(a0, 0, "data after halt");
        m.stop_cond();
        repeat (CONV + 50) @(negedge i_clock);
        r0 = rises;
        repeat (400) @(negedge i_clock);
        chk(rises - r0, 0, "no restart after halt");
        chk(converting, 0, "converter idle");
        end_test("continuous");
    endtask

    task automatic t_fetch(input logic [12:0] v);
        logic a0, a1;
        logic [7:0] b0, b1;
        open_cmd(`CMD_FETCH, a0, a1);
        chk(a1, 1, "fetch ack");
        turn_read();
        m.read_byte(1'b1, b0);
        m.read_byte(1'b0, b1);
        m.stop_cond();
        chk(b0, v[12:5], "result high byte");
        chk(b1, {v[4:0], 3'h0}, "result low byte");
        end_test("fetch");
    endtask

    task automatic t_setup(input logic [7:0] v);
        logic a0, a1;
        logic [7:0] b0;
        open_cmd(`CMD_SETUP, a0, a1);
        chk(a1, 1, "setup ack");
        m.write_byte(v, a0);
        chk(a0, 1, "setup data ack");
        m.stop_cond();
        wait_prog();
        open_cmd(`CMD_SETUP, a0, a1);
        turn_read();
        m.read_byte(1'b0, b0);
        m.stop_cond();
        chk(b0, {1'b1, `CFG_FIXED, v[0]}, "setup readback");
        end_test("setup");
    endtask

    task automatic t_single();
        int r0;
        logic a0, a1;
        sensor = 13'h0c37;
        r0 = rises;
        open_cmd(`CMD_BEGIN, a0, a1);
        chk(a1, 1, "begin ack");
        m.stop_cond();
        repeat (600) @(negedge i_clock);
        chk(rises - r0, 1, "one conversion per begin");
        t_fetch(13'h0c37);
        end_test("single");
    endtask

    task automatic t_storage();
        logic a0, a1;
        logic [7:0] b0;
        open_cmd(`CMD_STORAGE, a0, a1);
        chk(a1, 1, "storage ack");
        m.write_byte(8'h05, a0);
        m.write_byte(8'h3c, a1);
        chk({a0, a1}, 2'h3, "storage write acks");
        m.stop_cond();
        wait_prog();
        open_cmd(`CMD_STORAGE, a0, a1);
        m.write_byte(8'h05, a0);
        turn_read();
        m.read_byte(1'b0, b0);
        m.stop_cond();
        chk(b0, 8'h3c, "storage readback");
        end_test("storage");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset is asynchronous in both domains, so a short hold clears them all except the storage array, which has no reset.
    initial begin
        fails = 0;
        n_compared = 0;
        rises = 0;
        cycles = 0;
        slow = 1'b0;
        pins = 3'h5;
        sensor = 13'h1a5b;
        i_rst_n = 1'b0;
        repeat (12) @(negedge i_clock);
        chk({sda_oe, converting, prog_busy}, 3'h0, "outputs in reset");
        i_rst_n = 1'b1;
        repeat (80) @(negedge i_clock);
        t_select();
        t_continuous();
        slow = 1'b1;
        t_fetch(13'h1a5b);
        slow = 1'b0;
        t_setup(8'h01);
        t_single();
        t_setup(8'h00);
        t_storage();
        report_and_stop();
    end
endmodule
